// file: rtl/daac_pkg.sv
// constants and types shared by the decimal adjust and add-with-carry slice
package daac_pkg;

  typedef enum logic [2:0] {
    OP_ADD_ADJ,
    OP_SUB_ADJ,
    OP_DIV_PREP,
    OP_MUL_ADJ,
    OP_ADC
  } daac_op_t;

  localparam logic [3:0] NIBBLE_MAX  = 4'h9;
  localparam logic [7:0] ADJ_SIX     = 8'h06;
  localparam logic [7:0] DEC_BASE    = 8'h0A;
  localparam logic [7:0] LOW_MASK    = 8'h0F;
  localparam logic [7:0] BYTE_ONE    = 8'h01;
  localparam int         BYTE_MSB    = 7;
  localparam int         WORD_MSB    = 15;
  localparam int         NIB_MSB     = 3;

  // result bytes and flags after reset
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [15:0] RST_WORD   = 16'h0000;
  localparam logic        RST_FLAG   = 1'b0;

endpackage

// file: rtl/daac_alu.sv
// decimal adjust and add-with-carry arithmetic slice, one cycle latency
//
// Operation
// [RQ1] add adjust: low nibble above 9 or aux set adds 6, bumps high, sets flags
// [RQ2] sub adjust: low nibble above 9 or aux set subtracts 6, drops high, sets flags
// [RQ3] both add and sub adjust finish by masking low byte with 0FH
// [RQ4] add or sub adjust without condition keeps high byte, clears aux and carry
// [RQ5] add and sub adjust may leave overflow, parity, sign, zero undefined
// [RQ6] div prep: low becomes high times ten plus low, high cleared, PSZ updated
// [RQ7] mul adjust: high gets low div ten, low gets low mod ten, PSZ updated
// [RQ8] software clears high before div prep and uses single-digit multiply operands
// [RQ9] add-with-carry sums dest, src and incoming carry, byte or word size
// [RQ10] add-with-carry updates aux, carry, overflow, sign, zero, parity
// [RQ11] add-with-carry carry out chains into the next add-with-carry
// [RQ12] all operations keep direction, interrupt enable and single step
// [RQ13] parity set when low eight result bits hold an even count of ones
// [RQ14] aux set on carry out of or borrow into the low four bits
// [RQ15] carry set on carry or borrow out of the top result bit
// [RQ16] overflow on signed misfit; sign is top bit; zero on zero result
`timescale 1ns/1ps
`default_nettype none

module daac_alu
  import daac_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        srst_i,
  input  wire logic        op_valid_i,
  input  wire daac_op_t    op_code_i,
  input  wire logic        op_word_i,
  input  wire logic [7:0]  low_byte_i,
  input  wire logic [7:0]  high_byte_i,
  input  wire logic [15:0] dest_i,
  input  wire logic [15:0] src_i,
  input  wire logic        carry_flag_i,
  input  wire logic        aux_carry_flag_i,
  input  wire logic        overflow_flag_i,
  input  wire logic        parity_flag_i,
  input  wire logic        sign_flag_i,
  input  wire logic        zero_flag_i,
  input  wire logic        direction_flag_i,
  input  wire logic        interrupt_enable_flag_i,
  input  wire logic        single_step_flag_i,
  output logic             done_o,
  output logic [7:0]       low_byte_o,
  output logic [7:0]       high_byte_o,
  output logic [15:0]      result_o,
  output logic             carry_flag_o,
  output logic             aux_carry_flag_o,
  output logic             overflow_flag_o,
  output logic             parity_flag_o,
  output logic             sign_flag_o,
  output logic             zero_flag_o,
  output logic             direction_flag_o,
  output logic             interrupt_enable_flag_o,
  output logic             single_step_flag_o
);

  function automatic logic even_ones(input logic [7:0] v);
    return ~^v;
  endfunction

  logic        done_ff,  nxt_done;
  logic [7:0]  low_ff,   nxt_low;
  logic [7:0]  high_ff,  nxt_high;
  logic [15:0] res_ff,   nxt_res;
  logic        cf_ff,    nxt_cf;
  logic        af_ff,    nxt_af;
  logic        of_ff,    nxt_of;
  logic        pf_ff,    nxt_pf;
  logic        sf_ff,    nxt_sf;
  logic        zf_ff,    nxt_zf;
  logic        df_ff,    nxt_df;
  logic        if_ff,    nxt_if;
  logic        tf_ff,    nxt_tf;

  logic        adj_cond;
  logic        op_legal;
  logic [15:0] prod;
  logic [4:0]  nib_sum;
  logic [8:0]  sum_b;
  logic [16:0] sum_w;
  logic [15:0] adc_res;
  logic        adc_msb;

  always_comb begin
    adj_cond = (low_byte_i[NIB_MSB:0] > NIBBLE_MAX) || aux_carry_flag_i;
    // unknown codes must not touch the held results or flags
    op_legal = op_code_i inside {OP_ADD_ADJ, OP_SUB_ADJ, OP_DIV_PREP,
                                 OP_MUL_ADJ, OP_ADC};
    prod     = high_byte_i * DEC_BASE;
    nib_sum  = {1'b0, dest_i[NIB_MSB:0]} + {1'b0, src_i[NIB_MSB:0]}
             + {4'h0, carry_flag_i};                                 // [RQ14]
    sum_b    = {1'b0, dest_i[BYTE_MSB:0]} + {1'b0, src_i[BYTE_MSB:0]}
             + {8'h00, carry_flag_i};                                // [RQ9]
    sum_w    = {1'b0, dest_i} + {1'b0, src_i}
             + {16'h0000, carry_flag_i};                             // [RQ9]
    adc_res  = op_word_i ? sum_w[WORD_MSB:0]
                         : {dest_i[WORD_MSB:8], sum_b[BYTE_MSB:0]};
    adc_msb  = op_word_i ? sum_w[WORD_MSB] : sum_b[BYTE_MSB];

    // registers other than done hold between operations; done clears
    nxt_done = 1'b0;
    nxt_low  = low_ff;
    nxt_high = high_ff;
    nxt_res  = res_ff;
    nxt_cf   = cf_ff;
    nxt_af   = af_ff;
    nxt_of   = of_ff;
    nxt_pf   = pf_ff;
    nxt_sf   = sf_ff;
    nxt_zf   = zf_ff;
    nxt_df   = df_ff;
    nxt_if   = if_ff;
    nxt_tf   = tf_ff;

    if (op_valid_i && op_legal) begin
      nxt_done = 1'b1;
      // undefined flags simply pass the incoming value through
      nxt_low  = low_byte_i;
      nxt_high = high_byte_i;
      nxt_cf   = carry_flag_i;
      nxt_af   = aux_carry_flag_i;
      nxt_of   = overflow_flag_i;                                    // [RQ5]
      nxt_pf   = parity_flag_i;
      nxt_sf   = sign_flag_i;
      nxt_zf   = zero_flag_i;
      nxt_df   = direction_flag_i;                                   // [RQ12]
      nxt_if   = interrupt_enable_flag_i;                            // [RQ12]
      nxt_tf   = single_step_flag_i;                                 // [RQ12]
      unique case (op_code_i)
        OP_ADD_ADJ: begin
          if (adj_cond) begin
            nxt_low  = (low_byte_i + ADJ_SIX) & LOW_MASK;            // [RQ1] [RQ3]
            nxt_high = high_byte_i + BYTE_ONE;                       // [RQ1]
          end else begin
            nxt_low  = low_byte_i & LOW_MASK;                        // [RQ3]
          end
          nxt_af = adj_cond;                                         // [RQ1] [RQ4]
          nxt_cf = adj_cond;                                         // [RQ1] [RQ4]
        end
        OP_SUB_ADJ: begin
          if (adj_cond) begin
            nxt_low  = (low_byte_i - ADJ_SIX) & LOW_MASK;            // [RQ2] [RQ3]
            nxt_high = high_byte_i - BYTE_ONE;                       // [RQ2]
          end else begin
            nxt_low  = low_byte_i & LOW_MASK;                        // [RQ3]
          end
          nxt_af = adj_cond;                                         // [RQ2] [RQ4]
          nxt_cf = adj_cond;                                         // [RQ2] [RQ4]
        end
        OP_DIV_PREP: begin
          // a high byte times ten plus low above 255 wraps modulo 256; software keeps it small
          nxt_low  = prod[7:0] + low_byte_i;                         // [RQ6] [RQ8]
          nxt_high = RST_BYTE;                                       // [RQ6]
          nxt_pf   = even_ones(nxt_low);                             // [RQ13]
          nxt_sf   = nxt_low[BYTE_MSB];                              // [RQ16]
          nxt_zf   = (nxt_low == RST_BYTE);                          // [RQ16]
        end
        OP_MUL_ADJ: begin
          nxt_high = low_byte_i / DEC_BASE;                          // [RQ7]
          nxt_low  = low_byte_i % DEC_BASE;                          // [RQ7]
          nxt_pf   = even_ones(nxt_low);                             // [RQ13]
          nxt_sf   = nxt_low[BYTE_MSB];                              // [RQ16]
          nxt_zf   = (nxt_low == RST_BYTE);                          // [RQ16]
        end
        OP_ADC: begin
          nxt_res = adc_res;                                         // [RQ9]
          nxt_af  = nib_sum[4];                                      // [RQ10] [RQ14]
          nxt_cf  = op_word_i ? sum_w[16] : sum_b[8];                // [RQ11] [RQ15]
          nxt_of  = op_word_i
                  ? (dest_i[WORD_MSB] == src_i[WORD_MSB]) &&
                    (adc_msb != dest_i[WORD_MSB])
                  : (dest_i[BYTE_MSB] == src_i[BYTE_MSB]) &&
                    (adc_msb != dest_i[BYTE_MSB]);                   // [RQ16]
          nxt_pf  = even_ones(adc_res[7:0]);                         // [RQ13]
          nxt_sf  = adc_msb;                                         // [RQ16]
          nxt_zf  = op_word_i ? (adc_res == RST_WORD)
                              : (adc_res[7:0] == RST_BYTE);          // [RQ16]
        end
        default: nxt_done = 1'b0;
      endcase
      if (op_code_i != OP_ADC) begin
        nxt_res = {nxt_high, nxt_low};
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      done_ff <= 1'b0;
      low_ff  <= RST_BYTE;
      high_ff <= RST_BYTE;
      res_ff  <= RST_WORD;
      cf_ff   <= RST_FLAG;
      af_ff   <= RST_FLAG;
      of_ff   <= RST_FLAG;
      pf_ff   <= RST_FLAG;
      sf_ff   <= RST_FLAG;
      zf_ff   <= RST_FLAG;
      df_ff   <= RST_FLAG;
      if_ff   <= RST_FLAG;
      tf_ff   <= RST_FLAG;
    end else begin
      done_ff <= nxt_done;
      low_ff  <= nxt_low;
      high_ff <= nxt_high;
      res_ff  <= nxt_res;
      cf_ff   <= nxt_cf;
      af_ff   <= nxt_af;
      of_ff   <= nxt_of;
      pf_ff   <= nxt_pf;
      sf_ff   <= nxt_sf;
      zf_ff   <= nxt_zf;
      df_ff   <= nxt_df;
      if_ff   <= nxt_if;
      tf_ff   <= nxt_tf;
    end
  end

  assign done_o                  = done_ff;
  assign low_byte_o              = low_ff;
  assign high_byte_o             = high_ff;
  assign result_o                = res_ff;
  assign carry_flag_o            = cf_ff;
  assign aux_carry_flag_o        = af_ff;
  assign overflow_flag_o         = of_ff;
  assign parity_flag_o           = pf_ff;
  assign sign_flag_o             = sf_ff;
  assign zero_flag_o             = zf_ff;
  assign direction_flag_o        = df_ff;
  assign interrupt_enable_flag_o = if_ff;
  assign single_step_flag_o      = tf_ff;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  add_adj_fix_a: assert property (                                   // [RQ1]
    op_valid_i && op_code_i == OP_ADD_ADJ && adj_cond |=>
      done_o && carry_flag_o && aux_carry_flag_o &&
      high_byte_o == 8'($past(high_byte_i) + 8'h01) &&
      low_byte_o == (8'($past(low_byte_i) + 8'h06) & 8'h0F))
    else $error("add adjust result wrong");

  sub_adj_fix_a: assert property (                                   // [RQ2]
    op_valid_i && op_code_i == OP_SUB_ADJ && adj_cond |=>
      carry_flag_o && aux_carry_flag_o &&
      high_byte_o == 8'($past(high_byte_i) - 8'h01) &&
      low_byte_o == (8'($past(low_byte_i) - 8'h06) & 8'h0F))
    else $error("sub adjust result wrong");

  adj_mask_a: assert property (                                      // [RQ3]
    op_valid_i && (op_code_i == OP_ADD_ADJ || op_code_i == OP_SUB_ADJ)
      |=> low_byte_o[7:4] == 4'h0)
    else $error("adjust left upper nibble set");

  adj_idle_a: assert property (                                      // [RQ4]
    op_valid_i && (op_code_i == OP_ADD_ADJ || op_code_i == OP_SUB_ADJ)
      && !adj_cond |=> !carry_flag_o && !aux_carry_flag_o &&
      high_byte_o == $past(high_byte_i))
    else $error("adjust without condition changed state");

  div_prep_a: assert property (                                      // [RQ6]
    op_valid_i && op_code_i == OP_DIV_PREP |=> high_byte_o == 8'h00 &&
      low_byte_o == 8'($past(high_byte_i) * 8'h0A + $past(low_byte_i)) &&
      zero_flag_o == (low_byte_o == 8'h00))
    else $error("div prep result wrong");

  mul_adj_a: assert property (                                       // [RQ7]
    op_valid_i && op_code_i == OP_MUL_ADJ |=>
      16'(high_byte_o * 8'h0A) + 16'(low_byte_o) == 16'($past(low_byte_i))
      && low_byte_o < 8'h0A && parity_flag_o == ~^low_byte_o)
    else $error("mul adjust result wrong");

  adc_word_a: assert property (                                      // [RQ9]
    op_valid_i && op_code_i == OP_ADC && op_word_i |=>
      {carry_flag_o, result_o} == 17'($past(dest_i)) + 17'($past(src_i))
      + 17'($past(carry_flag_i)))
    else $error("word add with carry wrong");

  adc_flags_a: assert property (                                     // [RQ16]
    op_valid_i && op_code_i == OP_ADC && !op_word_i |=>
      sign_flag_o == result_o[7] && zero_flag_o == (result_o[7:0] == 8'h00)
      && result_o[15:8] == $past(dest_i[15:8]))
    else $error("byte add with carry flags wrong");

  keep_ctl_a: assert property (                                      // [RQ12]
    op_valid_i && op_legal |=> done_o
      && direction_flag_o == $past(direction_flag_i)
      && single_step_flag_o == $past(single_step_flag_i)
      && interrupt_enable_flag_o == $past(interrupt_enable_flag_i))
    else $error("control flags not preserved");

  idle_hold_a: assert property (
    !op_valid_i |=> !done_o && $stable(result_o) && $stable(carry_flag_o))
    else $error("state moved without an operation");

  add_adj_c: cover property (op_valid_i && op_code_i == OP_ADD_ADJ
                             && adj_cond);
  div_prep_c: cover property (op_valid_i && op_code_i == OP_DIV_PREP);
  adc_chain_c: cover property (op_valid_i && op_code_i == OP_ADC
                               && op_word_i ##1 done_o && carry_flag_o
                               ##0 op_valid_i && op_code_i == OP_ADC);

endmodule

`default_nettype wire

// file: test/daac_alu_tb.sv
// self-checking bench for the decimal adjust and add-with-carry slice
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_fail++; \
  $display("wrong value t=%0t got %0h exp %0h", $time, got, exp); end end

module tb;
  import daac_pkg::*;
  logic        sys_clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        op_valid_i = 1'b0;
  daac_op_t    op_code_i = OP_ADC;
  logic        op_word_i = 1'b0;
  logic [7:0]  low_byte_i = 8'h00;
  logic [7:0]  high_byte_i = 8'h00;
  logic [15:0] dest_i = 16'h0000;
  logic [15:0] src_i = 16'h0000;
  logic        carry_flag_i = 1'b0;
  logic        aux_carry_flag_i = 1'b0;
  logic        pass_i = 1'b1;
  logic        direction_flag_i = 1'b0;
  logic        interrupt_enable_flag_i = 1'b0;
  logic        single_step_flag_i = 1'b0;
  logic        done_o, carry_flag_o, aux_carry_flag_o, overflow_flag_o;
  logic        parity_flag_o, sign_flag_o, zero_flag_o, direction_flag_o;
  logic        interrupt_enable_flag_o, single_step_flag_o;
  logic [7:0]  low_byte_o, high_byte_o;
  logic [15:0] result_o;
  logic [2:0]  esys;
  int          n_fail = 0;
  int          checks = 0;

  always #4 sys_clk_i = ~sys_clk_i;

  daac_alu daac_alu_inst (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .op_valid_i(op_valid_i), .op_code_i(op_code_i), .op_word_i(op_word_i),
    .low_byte_i(low_byte_i), .high_byte_i(high_byte_i), .dest_i(dest_i),
    .src_i(src_i), .carry_flag_i(carry_flag_i),
    .aux_carry_flag_i(aux_carry_flag_i), .overflow_flag_i(pass_i),
    .parity_flag_i(pass_i), .sign_flag_i(pass_i), .zero_flag_i(pass_i),
    .direction_flag_i(direction_flag_i),
    .interrupt_enable_flag_i(interrupt_enable_flag_i),
    .single_step_flag_i(single_step_flag_i), .done_o(done_o),
    .low_byte_o(low_byte_o), .high_byte_o(high_byte_o), .result_o(result_o),
    .carry_flag_o(carry_flag_o), .aux_carry_flag_o(aux_carry_flag_o),
    .overflow_flag_o(overflow_flag_o), .parity_flag_o(parity_flag_o),
    .sign_flag_o(sign_flag_o), .zero_flag_o(zero_flag_o),
    .direction_flag_o(direction_flag_o),
    .interrupt_enable_flag_o(interrupt_enable_flag_o),
    .single_step_flag_o(single_step_flag_o));

  // called at a falling edge; system flags vary with the data
  task automatic drive(daac_op_t oc, logic w, logic [7:0] lo, hi,
                       logic [15:0] d, s, logic cin, af);
    op_valid_i = 1'b1;
    op_code_i = oc;
    op_word_i = w;
    low_byte_i = lo;
    high_byte_i = hi;
    dest_i = d;
    src_i = s;
    carry_flag_i = cin;
    aux_carry_flag_i = af;
    direction_flag_i = lo[0];
    interrupt_enable_flag_i = ~lo[1];
    single_step_flag_i = d[0] ^ hi[0];
    esys = {lo[0], ~lo[1], d[0] ^ hi[0]};
  endtask

  // latency is fixed at one cycle, so done is looked at one edge later
  task automatic do_op(daac_op_t oc, logic w, logic [7:0] lo, hi,
                       logic [15:0] d, s, logic cin, af);
    @(negedge sys_clk_i);
    drive(oc, w, lo, hi, d, s, cin, af);
    @(negedge sys_clk_i);
    op_valid_i = 1'b0;
    `CHK(done_o, 1'b1)
    `CHK({direction_flag_o, interrupt_enable_flag_o, single_step_flag_o},
         esys)
  endtask

  task automatic adj(daac_op_t oc, logic [7:0] lo, hi, logic af,
                     logic [7:0] elo, ehi, logic e);
    do_op(oc, 1'b0, lo, hi, 16'h0000, 16'h0000, 1'b0, af);
    `CHK(low_byte_o, elo)
    `CHK(high_byte_o, ehi)
    `CHK({carry_flag_o, aux_carry_flag_o}, {e, e})
  endtask

  task automatic psz(daac_op_t oc, logic [7:0] lo, hi, elo, ehi,
                     logic [2:0] e);
    do_op(oc, 1'b0, lo, hi, 16'h0000, 16'h0000, 1'b0, 1'b0);
    `CHK({high_byte_o, low_byte_o}, {ehi, elo})
    `CHK({parity_flag_o, sign_flag_o, zero_flag_o}, e)
  endtask

  // flags expected as {carry, aux, overflow, parity, sign, zero}
  task automatic adc(logic w, logic [15:0] d, s, logic cin,
                     logic [15:0] er, logic [5:0] ef);
    do_op(OP_ADC, w, 8'h00, 8'h00, d, s, cin, 1'b0);
    `CHK(result_o, er)
    `CHK({carry_flag_o, aux_carry_flag_o, overflow_flag_o, parity_flag_o,
          sign_flag_o, zero_flag_o}, ef)
  endtask

  task automatic t_add_adj;
    adj(OP_ADD_ADJ, 8'h0B, 8'h01, 1'b0, 8'h01, 8'h02, 1'b1);
    adj(OP_ADD_ADJ, 8'h03, 8'h05, 1'b1, 8'h09, 8'h06, 1'b1);
    adj(OP_ADD_ADJ, 8'h39, 8'hFF, 1'b0, 8'h09, 8'hFF, 1'b0);
    adj(OP_ADD_ADJ, 8'h3A, 8'hFF, 1'b0, 8'h00, 8'h00, 1'b1);
  endtask

  task automatic t_sub_adj;
    adj(OP_SUB_ADJ, 8'h0F, 8'h03, 1'b0, 8'h09, 8'h02, 1'b1);
    adj(OP_SUB_ADJ, 8'h02, 8'h00, 1'b1, 8'h0C, 8'hFF, 1'b1);
    adj(OP_SUB_ADJ, 8'h07, 8'h04, 1'b0, 8'h07, 8'h04, 1'b0);
    adj(OP_SUB_ADJ, 8'h0A, 8'h01, 1'b0, 8'h04, 8'h00, 1'b1);
  endtask

  task automatic t_div_mul;
    psz(OP_DIV_PREP, 8'h05, 8'h07, 8'h4B, 8'h00, 3'b100);
    psz(OP_DIV_PREP, 8'h00, 8'h00, 8'h00, 8'h00, 3'b101);
    psz(OP_DIV_PREP, 8'h08, 8'h0C, 8'h80, 8'h00, 3'b010);
    psz(OP_DIV_PREP, 8'h09, 8'h09, 8'h63, 8'h00, 3'b100);
    psz(OP_MUL_ADJ, 8'h51, 8'hA5, 8'h01, 8'h08, 3'b000);
    psz(OP_MUL_ADJ, 8'h00, 8'hA5, 8'h00, 8'h00, 3'b101);
    psz(OP_MUL_ADJ, 8'h63, 8'h00, 8'h09, 8'h09, 3'b100);
  endtask

  task automatic t_adc;
    adc(1'b1, 16'hFFFF, 16'h0001, 1'b0, 16'h0000, 6'b110101);
    adc(1'b0, 16'h127F, 16'h0000, 1'b1, 16'h1280, 6'b011010);
    adc(1'b1, 16'h7FFF, 16'h0000, 1'b1, 16'h8000, 6'b011110);
    adc(1'b0, 16'h00FF, 16'h0001, 1'b0, 16'h0000, 6'b110101);
    adc(1'b1, 16'h00FF, 16'h0001, 1'b0, 16'h0100, 6'b010100);
    adc(1'b1, 16'h8000, 16'h8000, 1'b0, 16'h0000, 6'b101101);
    adc(1'b0, 16'h0050, 16'h0050, 1'b0, 16'h00A0, 6'b001110);
  endtask

  // 32-bit sum built from two word adds with the carry fed back
  task automatic t_chain;
    adc(1'b1, 16'hFFFF, 16'h0001, 1'b0, 16'h0000, 6'b110101);
    adc(1'b1, 16'h0001, 16'h0002, carry_flag_o, 16'h0004, 6'b000000);
  endtask

  // unused code must not disturb held outputs; then two ops back to back
  task automatic t_illegal_b2b;
    @(negedge sys_clk_i);
    drive(daac_op_t'(3'h6), 1'b1, 8'h33, 8'h44, 16'h1111, 16'h1111,
          1'b0, 1'b0);
    @(negedge sys_clk_i);
    `CHK(done_o, 1'b0)
    `CHK(result_o, 16'h0004)
    drive(OP_ADC, 1'b1, 8'h00, 8'h00, 16'h0001, 16'h0001, 1'b1, 1'b0);
    @(negedge sys_clk_i);
    `CHK(result_o, 16'h0003)
    drive(OP_ADD_ADJ, 1'b0, 8'h0B, 8'h01, 16'h0000, 16'h0000, 1'b0, 1'b0);
    @(negedge sys_clk_i);
    op_valid_i = 1'b0;
    `CHK({done_o, high_byte_o, low_byte_o}, 17'h10201)
    @(negedge sys_clk_i);
    `CHK({done_o, high_byte_o, low_byte_o}, 17'h00201)
  endtask

  task final_report;
    if (n_fail == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    #400000;
    n_fail++;
    final_report();
  end

  initial begin
    repeat (5) @(negedge sys_clk_i);
    srst_i = 1'b0;
    t_add_adj();
    t_sub_adj();
    t_div_mul();
    t_adc();
    t_chain();
    t_illegal_b2b();
    final_report();
  end
endmodule

`default_nettype wire
